// File: rtl/bsi_pkg.sv
// Package: constants and types shared by the boundary-scan instruction logic
package bsi_pkg;

    // ************************************************************
    // Register lengths
    // ************************************************************
    localparam int IR_LEN = 10;
    localparam int ID_LEN = 32;
    localparam int SYNC_STAGES = 2;

    // ************************************************************
    // Instruction codes and reset values
    // ************************************************************
    localparam logic [IR_LEN-1:0] OP_BYPASS = 10'h3ff;
    localparam logic [IR_LEN-1:0] OP_SAMPLE = 10'h005;
    localparam logic [IR_LEN-1:0] OP_EXTEST = 10'h00f;
    localparam logic [IR_LEN-1:0] OP_IDCODE = 10'h006;
    localparam logic [IR_LEN-1:0] OP_USERCODE = 10'h007;
    localparam logic [IR_LEN-1:0] OP_CLAMP = 10'h00a;
    localparam logic [IR_LEN-1:0] OP_HIGHZ = 10'h00b;
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h155;
    localparam logic [ID_LEN-1:0] USERCODE_UNCONFIG = 32'h0000_0000;
    localparam logic [ID_LEN-1:0] SIG_RESET = 32'h0000_0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [15:0] {
        BSI_TLR = 16'h0001,
        BSI_RTI = 16'h0002,
        BSI_SEL_DR = 16'h0004,
        BSI_CAP_DR = 16'h0008,
        BSI_SH_DR = 16'h0010,
        BSI_EX1_DR = 16'h0020,
        BSI_PAU_DR = 16'h0040,
        BSI_EX2_DR = 16'h0080,
        BSI_UP_DR = 16'h0100,
        BSI_SEL_IR = 16'h0200,
        BSI_CAP_IR = 16'h0400,
        BSI_SH_IR = 16'h0800,
        BSI_EX1_IR = 16'h1000,
        BSI_PAU_IR = 16'h2000,
        BSI_EX2_IR = 16'h4000,
        BSI_UP_IR = 16'h8000
    } bsi_tap_t;

    typedef enum logic [2:0] {
        K_BYPASS = 3'h0,
        K_SAMPLE = 3'h1,
        K_EXTEST = 3'h2,
        K_IDCODE = 3'h3,
        K_USERCODE = 3'h4,
        K_CLAMP = 3'h5,
        K_HIGHZ = 3'h6
    } bsi_kind_t;

endpackage

// File: rtl/bsi_sync.sv
// Two-stage level synchroniser, one bit per lane
`timescale 1ns/1ps
`default_nettype none
module bsi_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule
`default_nettype wire

// File: rtl/bsi_top.sv
// Boundary-scan test port: TAP, instruction and data registers, pin multiplexers
`timescale 1ns/1ps
`default_nettype none
// Function
// - Sample capture takes live core pin signals
// - Sample leaves core data driving the pins
// - Shift chains cells from TDI to TDO
// - Update copies capture cells into update cells
// - Captured data leaves first, TDI after chain
// - TMS low holds shift-DR after capture-DR
// - Two TMS-high cycles reach update-DR
// - Enable cells capture core enables, pins aside
// - Extest drives pins from update cells
// - Extest captures pin values, updates new data
// - All-ones instruction selects bypass
// - Bypass samples rising edge, drives falling
// - Idcode loads fixed 32-bit identification value
// - Usercode loads 32-bit user signature
// - Signature valid only once configured
// - Usercode returns running design's signature
// - Clamp drives pins from cells, bypass path
// - Clamp keeps pull-up and bus-hold active
// - Highz tri-states pins, bypass path
// - Highz keeps pull-up and bus-hold active
// - Instructions are ten bits long
// - Bypass register is one bit
// - Test-logic-reset disables scan, loads idcode
// - TDO driven only in shift states
module bsi_top #(
    parameter int NPINS = 8,
    parameter logic [31:0] ID_VALUE = 32'h0a5c_3001 // Arbitrary value
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Scan link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Core side
    input wire logic [NPINS-1:0] core_out,
    input wire logic [NPINS-1:0] core_oe,
    input wire logic [NPINS-1:0] pin_keep_en,
    input wire logic goe_feature_en,
    // Configuration
    input wire logic [31:0] flash_signature,
    input wire logic sram_load,
    output logic configured,
    // Pins
    input wire logic global_output_enable_pin,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    output logic [NPINS-1:0] pin_keeper_en
);
    localparam int BSR_LEN = 3 * NPINS;
    localparam int TW = 3 * NPINS + 33;
    localparam int SW = 2 * NPINS + 3;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic bsi_pkg::bsi_tap_t tap_next(bsi_pkg::bsi_tap_t s, logic m);
        bsi_pkg::bsi_tap_t n;
        n = bsi_pkg::BSI_TLR;
        case (s)
            bsi_pkg::BSI_TLR: n = m ? bsi_pkg::BSI_TLR : bsi_pkg::BSI_RTI;
            bsi_pkg::BSI_RTI: n = m ? bsi_pkg::BSI_SEL_DR : bsi_pkg::BSI_RTI;
            bsi_pkg::BSI_SEL_DR: n = m ? bsi_pkg::BSI_SEL_IR : bsi_pkg::BSI_CAP_DR;
            bsi_pkg::BSI_CAP_DR: n = m ? bsi_pkg::BSI_EX1_DR : bsi_pkg::BSI_SH_DR;
            bsi_pkg::BSI_SH_DR: n = m ? bsi_pkg::BSI_EX1_DR : bsi_pkg::BSI_SH_DR;
            bsi_pkg::BSI_EX1_DR: n = m ? bsi_pkg::BSI_UP_DR : bsi_pkg::BSI_PAU_DR;
            bsi_pkg::BSI_PAU_DR: n = m ? bsi_pkg::BSI_EX2_DR : bsi_pkg::BSI_PAU_DR;
            bsi_pkg::BSI_EX2_DR: n = m ? bsi_pkg::BSI_UP_DR : bsi_pkg::BSI_SH_DR;
            bsi_pkg::BSI_UP_DR: n = m ? bsi_pkg::BSI_SEL_DR : bsi_pkg::BSI_RTI;
            bsi_pkg::BSI_SEL_IR: n = m ? bsi_pkg::BSI_TLR : bsi_pkg::BSI_CAP_IR;
            bsi_pkg::BSI_CAP_IR: n = m ? bsi_pkg::BSI_EX1_IR : bsi_pkg::BSI_SH_IR;
            bsi_pkg::BSI_SH_IR: n = m ? bsi_pkg::BSI_EX1_IR : bsi_pkg::BSI_SH_IR;
            bsi_pkg::BSI_EX1_IR: n = m ? bsi_pkg::BSI_UP_IR : bsi_pkg::BSI_PAU_IR;
            bsi_pkg::BSI_PAU_IR: n = m ? bsi_pkg::BSI_EX2_IR : bsi_pkg::BSI_PAU_IR;
            bsi_pkg::BSI_EX2_IR: n = m ? bsi_pkg::BSI_UP_IR : bsi_pkg::BSI_SH_IR;
            bsi_pkg::BSI_UP_IR: n = m ? bsi_pkg::BSI_SEL_DR : bsi_pkg::BSI_RTI;
            default: n = bsi_pkg::BSI_TLR;
        endcase
        return n;
    endfunction

    // Unknown codes fall back to bypass
    function automatic bsi_pkg::bsi_kind_t decode(logic [bsi_pkg::IR_LEN-1:0] op);
        bsi_pkg::bsi_kind_t k;
        k = bsi_pkg::K_BYPASS;
        if (op == bsi_pkg::OP_SAMPLE) begin
            k = bsi_pkg::K_SAMPLE;
        end else if (op == bsi_pkg::OP_EXTEST) begin
            k = bsi_pkg::K_EXTEST;
        end else if (op == bsi_pkg::OP_IDCODE) begin
            k = bsi_pkg::K_IDCODE;
        end else if (op == bsi_pkg::OP_USERCODE) begin
            k = bsi_pkg::K_USERCODE;
        end else if (op == bsi_pkg::OP_CLAMP) begin
            k = bsi_pkg::K_CLAMP;
        end else if (op == bsi_pkg::OP_HIGHZ) begin
            k = bsi_pkg::K_HIGHZ;
        end
        return k;
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    bsi_pkg::bsi_tap_t st_ff;
    bsi_pkg::bsi_tap_t nxt_st;
    bsi_pkg::bsi_kind_t kind_ff;
    logic [bsi_pkg::IR_LEN-1:0] ir_sh_ff;
    logic [bsi_pkg::IR_LEN-1:0] ir_ff;
    logic mode_upd_ff;
    logic mode_hiz_ff;
    logic [BSR_LEN-1:0] bsr_ff;
    logic [BSR_LEN-1:0] cap_par;
    logic [NPINS-1:0] upd_out_ff;
    logic [NPINS-1:0] upd_oe_ff;
    logic [bsi_pkg::ID_LEN-1:0] id_ff;
    logic byp_ff;
    logic tdo_ff;
    logic tdo_oe_ff;
    logic bsr_sel;
    logic id_sel;
    logic dr_out;
    logic [TW-1:0] t_s;
    logic [NPINS-1:0] core_out_t;
    logic [NPINS-1:0] core_oe_t;
    logic [NPINS-1:0] pin_in_t;
    logic cfg_t;
    logic [31:0] sig_t;
    logic [SW-1:0] s_s;
    logic goe_pin_s;
    logic [NPINS-1:0] upd_out_s;
    logic [NPINS-1:0] upd_oe_s;
    logic use_upd_s;
    logic hiz_s;
    logic cfg_ff;
    logic [31:0] sig_ff;
    logic [NPINS-1:0] pin_out_ff;
    logic [NPINS-1:0] pin_oe_ff;
    logic [NPINS-1:0] keeper_ff;

    // ************************************************************
    // Crossings
    // ************************************************************
    // Signature and core signals are levels; scan users sample them well after they settle
    bsi_sync #(.WIDTH(TW)) u_sync_tck (
        .clk(tck),
        .rst_n(rst_n),
        .d({sig_ff, cfg_ff, pin_in, core_oe, core_out}),
        .q(t_s)
    );
    assign core_out_t = t_s[NPINS-1:0];
    assign core_oe_t = t_s[2*NPINS-1:NPINS];
    assign pin_in_t = t_s[3*NPINS-1:2*NPINS];
    assign cfg_t = t_s[3*NPINS];
    assign sig_t = t_s[TW-1:3*NPINS+1];

    // Update cells change only in update-DR, so a per-bit sync is safe between updates
    bsi_sync #(.WIDTH(SW)) u_sync_sys (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d({mode_hiz_ff, mode_upd_ff, upd_oe_ff, upd_out_ff, global_output_enable_pin}),
        .q(s_s)
    );
    assign goe_pin_s = s_s[0];
    assign upd_out_s = s_s[NPINS:1];
    assign upd_oe_s = s_s[2*NPINS:NPINS+1];
    assign use_upd_s = s_s[2*NPINS+1];
    assign hiz_s = s_s[2*NPINS+2];

    // ************************************************************
    // TAP state machine
    // ************************************************************
    assign nxt_st = tap_next(st_ff, tms);

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= bsi_pkg::BSI_TLR;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // Instruction register
    // ************************************************************
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_ff <= bsi_pkg::IR_CAPTURE;
        end else if (st_ff == bsi_pkg::BSI_CAP_IR) begin
            ir_sh_ff <= bsi_pkg::IR_CAPTURE;
        end else if (st_ff == bsi_pkg::BSI_SH_IR) begin
            ir_sh_ff <= {tdi, ir_sh_ff[bsi_pkg::IR_LEN-1:1]};
        end
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ir_ff <= bsi_pkg::OP_IDCODE;
            kind_ff <= bsi_pkg::K_IDCODE;
            mode_upd_ff <= 1'b0;
            mode_hiz_ff <= 1'b0;
        end else if (st_ff == bsi_pkg::BSI_TLR) begin
            ir_ff <= bsi_pkg::OP_IDCODE;
            kind_ff <= decode(bsi_pkg::OP_IDCODE);
            mode_upd_ff <= 1'b0;
            mode_hiz_ff <= 1'b0;
        end else if (st_ff == bsi_pkg::BSI_UP_IR) begin
            ir_ff <= ir_sh_ff;
            kind_ff <= decode(ir_sh_ff);
            mode_upd_ff <= decode(ir_sh_ff) == bsi_pkg::K_EXTEST || decode(ir_sh_ff) == bsi_pkg::K_CLAMP;
            mode_hiz_ff <= decode(ir_sh_ff) == bsi_pkg::K_HIGHZ;
        end
    end

    // ************************************************************
    // Boundary register
    // ************************************************************
    assign bsr_sel = kind_ff == bsi_pkg::K_SAMPLE || kind_ff == bsi_pkg::K_EXTEST;

    // Three cells a pin: input, enable, output
    for (genvar p = 0; p < NPINS; p++) begin : g_cell
        assign cap_par[3*p] = pin_in_t[p];
        assign cap_par[3*p+1] = core_oe_t[p];
        assign cap_par[3*p+2] = core_out_t[p];
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            bsr_ff <= '0;
        end else if (bsr_sel && st_ff == bsi_pkg::BSI_CAP_DR) begin
            bsr_ff <= cap_par;
        end else if (bsr_sel && st_ff == bsi_pkg::BSI_SH_DR) begin
            bsr_ff <= {tdi, bsr_ff[BSR_LEN-1:1]};
        end
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            upd_out_ff <= '0;
            upd_oe_ff <= '0;
        end else if (bsr_sel && st_ff == bsi_pkg::BSI_UP_DR) begin
            for (int i = 0; i < NPINS; i++) begin
                upd_oe_ff[i] <= bsr_ff[3*i+1];
                upd_out_ff[i] <= bsr_ff[3*i+2];
            end
        end
    end

    // ************************************************************
    // Identification and bypass registers
    // ************************************************************
    assign id_sel = kind_ff == bsi_pkg::K_IDCODE || kind_ff == bsi_pkg::K_USERCODE;

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            id_ff <= '0;
        end else if (id_sel && st_ff == bsi_pkg::BSI_CAP_DR) begin
            if (kind_ff == bsi_pkg::K_IDCODE) begin
                id_ff <= ID_VALUE;
            end else if (cfg_t) begin
                id_ff <= sig_t;
            end else begin
                id_ff <= bsi_pkg::USERCODE_UNCONFIG;
            end
        end else if (id_sel && st_ff == bsi_pkg::BSI_SH_DR) begin
            id_ff <= {tdi, id_ff[bsi_pkg::ID_LEN-1:1]};
        end
    end

    // Single bit, so the path costs one TCK of latency
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            byp_ff <= 1'b0;
        end else if (st_ff == bsi_pkg::BSI_CAP_DR) begin
            byp_ff <= 1'b0;
        end else if (st_ff == bsi_pkg::BSI_SH_DR) begin
            byp_ff <= tdi;
        end
    end

    // ************************************************************
    // TDO, launched on the falling edge
    // ************************************************************
    assign dr_out = bsr_sel ? bsr_ff[0] : (id_sel ? id_ff[0] : byp_ff);

    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo_oe_ff <= 1'b0;
        end else begin
            tdo_oe_ff <= st_ff == bsi_pkg::BSI_SH_IR || st_ff == bsi_pkg::BSI_SH_DR;
        end
    end

    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo_ff <= 1'b0;
        end else begin
            tdo_ff <= st_ff == bsi_pkg::BSI_SH_IR ? ir_sh_ff[0] : dr_out;
        end
    end

    assign tdo = tdo_ff;
    assign tdo_oe = tdo_oe_ff;

    // ************************************************************
    // Configuration signature, system domain
    // ************************************************************
    // Reprogramming the flash alone never touches this copy
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= 1'b0;
            sig_ff <= bsi_pkg::SIG_RESET;
        end else if (sram_load) begin
            cfg_ff <= 1'b1;
            sig_ff <= flash_signature;
        end
    end

    assign configured = cfg_ff;

    // ************************************************************
    // Pin multiplexers, system domain
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
        end else if (hiz_s) begin
            pin_out_ff <= upd_out_s;
            pin_oe_ff <= '0;
        end else if (use_upd_s) begin
            pin_out_ff <= upd_out_s;
            pin_oe_ff <= upd_oe_s;
        end else begin
            pin_out_ff <= core_out;
            pin_oe_ff <= core_oe & {NPINS{~goe_feature_en | goe_pin_s}};
        end
    end

    // Keepers follow the core in every mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            keeper_ff <= '0;
        end else begin
            keeper_ff <= pin_keep_en;
        end
    end

    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign pin_keeper_en = keeper_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_shift_hold;
        @(posedge tck) disable iff (!rst_n) (st_ff == bsi_pkg::BSI_CAP_DR && !tms) ##1 !tms
            |=> st_ff == bsi_pkg::BSI_SH_DR;
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("shift-DR not held");

    property p_exit_update;
        @(posedge tck) disable iff (!rst_n) (st_ff == bsi_pkg::BSI_SH_DR && tms) ##1 tms
            |=> st_ff == bsi_pkg::BSI_UP_DR;
    endproperty
    a_exit_update: assert property (p_exit_update) else $error("update-DR not reached");

    property p_bsr_shift;
        @(posedge tck) disable iff (!rst_n) (bsr_sel && st_ff == bsi_pkg::BSI_SH_DR)
            |=> bsr_ff == {$past(tdi), $past(bsr_ff[BSR_LEN-1:1])};
    endproperty
    a_bsr_shift: assert property (p_bsr_shift) else $error("boundary shift wrong");

    property p_capture;
        @(posedge tck) disable iff (!rst_n) (bsr_sel && st_ff == bsi_pkg::BSI_CAP_DR) |=> bsr_ff == $past(cap_par);
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong");

    property p_update;
        @(posedge tck) disable iff (!rst_n) (bsr_sel && st_ff == bsi_pkg::BSI_UP_DR)
            |=> upd_out_ff[0] == $past(bsr_ff[2]) && upd_oe_ff[0] == $past(bsr_ff[1]);
    endproperty
    a_update: assert property (p_update) else $error("update cells wrong");

    property p_bypass;
        @(posedge tck) disable iff (!rst_n) (kind_ff == bsi_pkg::K_BYPASS && st_ff == bsi_pkg::BSI_SH_DR)
            |=> byp_ff == $past(tdi) && dr_out == $past(tdi);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass path wrong");

    property p_reset_idcode;
        @(posedge tck) disable iff (!rst_n) st_ff == bsi_pkg::BSI_TLR |=> ir_ff == bsi_pkg::OP_IDCODE && !mode_upd_ff;
    endproperty
    a_reset_idcode: assert property (p_reset_idcode) else $error("idcode not loaded");

    property p_idcode;
        @(posedge tck) disable iff (!rst_n) (kind_ff == bsi_pkg::K_IDCODE && st_ff == bsi_pkg::BSI_CAP_DR)
            |=> id_ff == ID_VALUE;
    endproperty
    a_idcode: assert property (p_idcode) else $error("idcode value wrong");

    property p_unconfig;
        @(posedge tck) disable iff (!rst_n) (kind_ff == bsi_pkg::K_USERCODE && st_ff == bsi_pkg::BSI_CAP_DR && !cfg_t)
            |=> id_ff == bsi_pkg::USERCODE_UNCONFIG;
    endproperty
    a_unconfig: assert property (p_unconfig) else $error("signature leaked");

    property p_tdo_en;
        @(negedge tck) disable iff (!rst_n) st_ff != bsi_pkg::BSI_SH_IR && st_ff != bsi_pkg::BSI_SH_DR |=> !tdo_oe;
    endproperty
    a_tdo_en: assert property (p_tdo_en) else $error("TDO driven outside shift");

    property p_highz;
        @(posedge clk_sys) disable iff (!rst_n) hiz_s |=> pin_oe == '0;
    endproperty
    a_highz: assert property (p_highz) else $error("pins not tri-stated");

    property p_functional;
        @(posedge clk_sys) disable iff (!rst_n) (!hiz_s && !use_upd_s) |=> pin_out == $past(core_out);
    endproperty
    a_functional: assert property (p_functional) else $error("core data not passed");

    c_extest: cover property (@(posedge tck) disable iff (!rst_n)
        kind_ff == bsi_pkg::K_EXTEST && st_ff == bsi_pkg::BSI_UP_DR);
    c_usercode: cover property (@(posedge tck) disable iff (!rst_n)
        kind_ff == bsi_pkg::K_USERCODE && cfg_t && st_ff == bsi_pkg::BSI_SH_DR);
    c_clamp: cover property (@(posedge clk_sys) disable iff (!rst_n) use_upd_s && !hiz_s);
endmodule
`default_nettype wire

// File: bench/bsi_host.sv
// Scan controller model driving the test link
`timescale 1ns/1ps
`default_nettype none
module bsi_host (
    // Scan link
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    int oe_bad = 0;
    // Tck stands low between frames; tdi idles at its pull-up level
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    task automatic step(input logic m, input logic d, input logic eo, output logic q);
        tms = m;
        tdi = d;
        #32 q = tdo;
        if (tdo_oe !== eo) oe_bad++;
        tck = 1'b1;
        #32 tck = 1'b0;
    endtask
    // Five high TMS cycles, then idle
    task automatic reset_tap;
        logic q;
        repeat (5) step(1'b1, 1'b1, 1'b0, q);
        step(1'b0, 1'b1, 1'b0, q);
    endtask
    // Idle edges first so the pin synchronisers see tck
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        logic q;
        dout = '0;
        repeat (2) step(1'b0, 1'b1, 1'b0, q);
        step(1'b1, 1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b1, 1'b0, q);
        step(1'b0, 1'b1, 1'b0, q);
        step(1'b0, 1'b1, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], 1'b1, q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, 1'b0, q);
        step(1'b0, 1'b1, 1'b0, q);
        tdi = 1'b1;
    endtask
endmodule
`default_nettype wire

// File: bench/bsi_tb_top.sv
// Self-checking bench for the boundary-scan instruction logic
`timescale 1ns/1ps
`default_nettype none
module bsi_tb_top;
    localparam int NP = 4;
    localparam logic [31:0] ID = 32'h5a3c_0f01; // Arbitrary value
    localparam logic [11:0] D1 = 12'h9c6;
    localparam logic [11:0] D2 = 12'h35a;
    logic clk_sys, rst_n, tck, tms, tdi, tdo, tdo_oe, goe_en, goe_pin, sram_load, configured;
    logic [NP-1:0] core_out, core_oe, keep, pin_in, pin_out, pin_oe, keeper;
    logic [31:0] flash;
    logic [63:0] r;
    int fail_count = 0;
    int checked = 0;
    bsi_top #(.NPINS(NP), .ID_VALUE(ID)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .pin_keep_en(keep),
        .goe_feature_en(goe_en), .flash_signature(flash), .sram_load(sram_load), .configured(configured),
        .global_output_enable_pin(goe_pin), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_keeper_en(keeper));
    bsi_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    // ************************************************************
    // Helpers
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("Compares %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic sys(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    function automatic logic [11:0] chain(input logic [NP-1:0] i, o, d);
        for (int p = 0; p < NP; p++) chain[3*p +: 3] = {d[p], o[p], i[p]};
    endfunction
    function automatic logic [NP-1:0] cells(input logic [11:0] c, input int s);
        for (int p = 0; p < NP; p++) cells[p] = c[3*p+s];
    endfunction
    task automatic load(input logic [9:0] op);
        u_host.scan(1'b1, 10, {54'h0, op}, r);
        check(r[9:0], 10'h155);
        sys(10);
    endtask
    task automatic sig_load(input logic [31:0] s);
        @(posedge clk_sys);
        flash <= s;
        sram_load <= 1'b1;
        @(posedge clk_sys);
        sram_load <= 1'b0;
        sys(5);
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_id_bypass;
        u_host.reset_tap();
        u_host.scan(1'b0, 32, 64'h0, r);
        check(r[31:0], ID);
        load(bsi_pkg::OP_BYPASS);
        u_host.scan(1'b0, 4, 64'hb, r);
        check(r[3:0], 4'h6);
        $display("idcode and bypass test done");
    endtask
    task automatic t_user;
        load(bsi_pkg::OP_USERCODE);
        u_host.scan(1'b0, 32, 64'h0, r);
        check(r[31:0], bsi_pkg::USERCODE_UNCONFIG);
        check(configured, 1'b0);
        sig_load(32'hc3a5_1e78);
        u_host.scan(1'b0, 32, 64'h0, r);
        check(r[31:0], 32'hc3a5_1e78);
        check(configured, 1'b1);
        @(posedge clk_sys);
        flash <= 32'h1b2d_4c6e;
        sys(5);
        u_host.scan(1'b0, 32, 64'h0, r);
        check(r[31:0], 32'hc3a5_1e78);
        sig_load(32'h1b2d_4c6e);
        u_host.scan(1'b0, 32, 64'h0, r);
        check(r[31:0], 32'h1b2d_4c6e);
        $display("usercode test done");
    endtask
    task automatic t_sample_extest;
        @(posedge clk_sys);
        core_out <= 4'ha;
        core_oe <= 4'h6;
        pin_in <= 4'h3;
        goe_en <= 1'b1;
        load(bsi_pkg::OP_SAMPLE);
        check(pin_out, 4'ha);
        check(pin_oe, 4'h0);
        u_host.scan(1'b0, 24, {40'h0, D1, D1}, r);
        check(r[11:0], chain(4'h3, 4'h6, 4'ha));
        check(r[23:12], D1);
        load(bsi_pkg::OP_EXTEST);
        check(pin_out, cells(D1, 2));
        check(pin_oe, cells(D1, 1));
        @(posedge clk_sys);
        pin_in <= 4'hc;
        sys(5);
        u_host.scan(1'b0, 12, {52'h0, D2}, r);
        check(r[11:0], chain(4'hc, 4'h6, 4'ha));
        sys(10);
        check(pin_out, cells(D2, 2));
        check(pin_oe, cells(D2, 1));
        $display("sample and extest test done");
    endtask
    task automatic t_clamp_highz;
        @(posedge clk_sys);
        keep <= 4'h5;
        load(bsi_pkg::OP_CLAMP);
        u_host.scan(1'b0, 2, 64'h1, r);
        check(r[1:0], 2'b10);
        check({pin_oe, pin_out}, {cells(D2, 1), cells(D2, 2)});
        check(keeper, 4'h5);
        load(bsi_pkg::OP_HIGHZ);
        check(pin_oe, 4'h0);
        @(posedge clk_sys);
        keep <= 4'ha;
        goe_pin <= 1'b1;
        sys(4);
        check(keeper, 4'ha);
        u_host.scan(1'b0, 2, 64'h1, r);
        check(r[1:0], 2'b10);
        load(bsi_pkg::OP_IDCODE);
        check({pin_oe, pin_out}, {4'h6, 4'ha});
        check(u_host.oe_bad, 0);
        $display("clamp and highz test done");
    endtask
    initial begin
        rst_n = 1'b0;
        {core_out, core_oe, keep, pin_in, goe_en, goe_pin, sram_load, flash} = '0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        sys(3);
        t_id_bypass();
        t_user();
        t_sample_extest();
        t_clamp_highz();
        print_verdict();
    end
    initial begin
        #200us;
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
